// ---- hdl/rbs_pkg.sv ----
// shared constants and types of the processor bus ends
// assumes one system clock; phases come as enable pulses
// What this block does
// - low normal interrupt accepted asynchronously, interrupts
// - fast interrupt same, but higher priority
// - reset: no-ops, then fetch from vector
// - abort input cancels the current bus cycle
// - 32-bit three-state data bus to memory
// - data drivers only while data enable high
// - byte/word low means single byte access
// - mode outputs are inverted status bits
// - 26 address lines, low two for bytes
// - word transfers put mode on low bits
// - address drivers only while address enable high
// - latch enable high: address changes in phase 2
// - rom systems hold latch enable low
// - read/write low reads, high writes, early
// - memory request low announces next cycle
// - translate low asks memory unit to translate
// - instruction fetch low for fetch cycles
// - sequential-next high for sequential next address
// - early warnings set late in preceding cycle
// - two non-overlapping phases from clock source
// - translate only in user mode or forced
package rbs_pkg;
	// ****************************************
	// widths and timing slots
	// ****************************************
	localparam int ADDR_W = 26;
	localparam int DATA_W = 32;
	localparam int PH_SLOTS = 4;
	localparam logic [1:0] PH1_SLOT = 2'h0;
	localparam logic [1:0] SAMPLE_SLOT = 2'h1;
	localparam logic [1:0] PH2_SLOT = 2'h2;
	localparam logic [1:0] CLEAR_SLOT = 2'h3;
	localparam logic [25:0] RESET_VECTOR = 26'h0000000;
	localparam logic [1:0] MODE_USER = 2'h0;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		RBS_HOLD = 2'b00,
		RBS_BOOT = 2'b01,
		RBS_RUN  = 2'b10
	} rbs_state_t;
endpackage : rbs_pkg

// ---- hdl/rbs_bus_if.sv ----
// pin bundle between processor end and memory end
// assumes both ends on clk_sys; levels resolved here
`timescale 1ns/10ps
interface rbs_bus_if;
	import rbs_pkg::*;
	logic              phase_1;
	logic              phase_2;
	logic              reset_in;
	logic              abort_in;
	logic              normal_interrupt_n;
	logic              fast_interrupt_n;
	logic              address_drive_enable;
	logic              data_drive_enable;
	logic              address_latch_enable;
	logic [ADDR_W-1:0] address_out;
	logic              address_oe;
	logic [DATA_W-1:0] cpu_data_out;
	logic              cpu_data_oe;
	logic [DATA_W-1:0] mem_data_out;
	logic              mem_data_oe;
	logic              byte_word_n;
	logic              read_write;
	logic              memory_request_next_n;
	logic              address_map_enable_n;
	logic              instruction_fetch_n;
	logic              burst_next;
	logic [1:0]        mode_outputs_n;
	logic [ADDR_W-1:0] address_lines;
	logic [DATA_W-1:0] data_lines;
	// ****************************************
	// wire levels
	// ****************************************
	assign address_lines = address_oe ? address_out : '0;
	assign data_lines = cpu_data_oe ? cpu_data_out :
		(mem_data_oe ? mem_data_out : '0);
	modport cpu (
		input  phase_1, phase_2, reset_in, abort_in,
		input  normal_interrupt_n, fast_interrupt_n,
		input  address_drive_enable, data_drive_enable,
		input  address_latch_enable, data_lines,
		output address_out, address_oe, cpu_data_out, cpu_data_oe,
		output byte_word_n, read_write, memory_request_next_n,
		output address_map_enable_n, instruction_fetch_n,
		output burst_next, mode_outputs_n
	);
	modport mem (
		output phase_1, phase_2, reset_in, abort_in,
		output normal_interrupt_n, fast_interrupt_n,
		output address_drive_enable, data_drive_enable,
		output address_latch_enable, mem_data_out, mem_data_oe,
		input  address_lines, data_lines, byte_word_n, read_write,
		input  memory_request_next_n, address_map_enable_n,
		input  instruction_fetch_n, burst_next, mode_outputs_n
	);
endinterface : rbs_bus_if

// ---- hdl/rbs_cpu_end.sv ----
// processor end of the external bus
// assumes phases and reset from the memory end on clk_sys
`timescale 1ns/10ps
module rbs_cpu_end
	import rbs_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	rbs_bus_if.cpu                 bus,
	input  wire logic              req_valid,
	input  wire logic              req_write,
	input  wire logic              req_byte,
	input  wire logic              req_fetch,
	input  wire logic              req_seq,
	input  wire logic              req_translate,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	input  wire logic [1:0]        mode_status,
	input  wire logic              irq_enable,
	input  wire logic              fast_interrupt_n_enable,
	output logic                   req_taken,
	output logic                   cyc_done,
	output logic                   cyc_aborted,
	output logic [DATA_W-1:0]      rd_data,
	output logic                   int_take,
	output logic                   int_fast,
	output logic                   nop_active
);
	// ****************************************
	// state
	// ****************************************
	rbs_state_t        state_reg;
	rbs_state_t        state_next;
	logic [1:0]        s1_reg;
	logic [1:0]        s2_reg;
	logic [1:0]        s3_reg;
	logic [1:0]        stable_reg;
	logic [1:0]        stable_next;
	logic              memory_request_next_n_n_reg;
	logic              memory_request_next_n_n_next;
	logic              rw_reg;
	logic              rw_next;
	logic              bw_n_reg;
	logic              bw_n_next;
	logic              opc_n_reg;
	logic              opc_n_next;
	logic              seq_reg;
	logic              seq_next;
	logic              address_map_enable_n_n_reg;
	logic              address_map_enable_n_n_next;
	logic [1:0]        mode_n_reg;
	logic [ADDR_W-1:0] pend_addr_reg;
	logic [ADDR_W-1:0] pend_addr_next;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;
	logic [DATA_W-1:0] pend_wd_reg;
	logic [DATA_W-1:0] pend_wd_next;
	logic [DATA_W-1:0] wd_reg;
	logic [DATA_W-1:0] wd_next;
	logic              act_reg;
	logic              act_next;
	logic              cw_reg;
	logic              cw_next;
	logic              taken_next;
	logic              done_next;
	logic              abt_next;
	logic [DATA_W-1:0] rd_next;
	logic              it_next;
	logic              if_next;
	logic              issue;
	logic              boot;
	logic [ADDR_W-1:0] new_addr;
	// ****************************************
	// pins
	// ****************************************
	assign bus.address_out = addr_reg;
	assign bus.address_oe = bus.address_drive_enable;
	assign bus.cpu_data_out = wd_reg;
	assign bus.cpu_data_oe = bus.data_drive_enable & act_reg
		& cw_reg;
	assign bus.byte_word_n = bw_n_reg;
	assign bus.read_write = rw_reg;
	assign bus.memory_request_next_n = memory_request_next_n_n_reg;
	assign bus.address_map_enable_n = address_map_enable_n_n_reg;
	assign bus.instruction_fetch_n = opc_n_reg;
	assign bus.burst_next = seq_reg;
	assign bus.mode_outputs_n = mode_n_reg;
	// ****************************************
	// interrupt synchroniser
	// ****************************************
	always_comb begin
		stable_next = stable_reg;
		if (s2_reg == s3_reg) begin
			stable_next = s3_reg;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s1_reg <= 2'h3;
			s2_reg <= 2'h3;
			s3_reg <= 2'h3;
			stable_reg <= 2'h3;
		end else begin
			s1_reg <= {bus.fast_interrupt_n,
				bus.normal_interrupt_n};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			stable_reg <= stable_next;
		end
	end
	// ****************************************
	// bus sequencer
	// ****************************************
	always_comb begin
		state_next = state_reg;
		memory_request_next_n_n_next = memory_request_next_n_n_reg;
		rw_next = rw_reg;
		bw_n_next = bw_n_reg;
		opc_n_next = opc_n_reg;
		seq_next = seq_reg;
		address_map_enable_n_n_next = address_map_enable_n_n_reg;
		pend_addr_next = pend_addr_reg;
		addr_next = addr_reg;
		pend_wd_next = pend_wd_reg;
		wd_next = wd_reg;
		act_next = act_reg;
		cw_next = cw_reg;
		taken_next = 1'b0;
		done_next = 1'b0;
		abt_next = 1'b0;
		rd_next = rd_data;
		it_next = 1'b0;
		if_next = int_fast;
		boot = (state_reg == RBS_BOOT);
		issue = bus.phase_2 && (boot ||
			(state_reg == RBS_RUN && req_valid));
		new_addr = boot ? RESET_VECTOR : req_addr;
		if (boot || !req_byte) begin
			new_addr[1:0] = mode_status;
		end
		if (bus.phase_1) begin
			addr_next = pend_addr_reg;
			act_next = !memory_request_next_n_n_reg;
			cw_next = rw_reg;
			wd_next = pend_wd_reg;
			if (state_reg == RBS_RUN) begin
				if (!stable_reg[1] && fast_interrupt_n_enable) begin
					it_next = 1'b1;
					if_next = 1'b1;
				end else if (!stable_reg[0] && irq_enable) begin
					it_next = 1'b1;
					if_next = 1'b0;
				end
			end
		end
		if (bus.phase_2) begin
			if (act_reg) begin
				act_next = 1'b0;
				if (bus.abort_in) begin
					abt_next = 1'b1;
				end else begin
					done_next = 1'b1;
					if (!cw_reg) begin
						rd_next = bus.data_lines;
					end
				end
			end
			memory_request_next_n_n_next = !issue;
			if (issue) begin
				rw_next = boot ? 1'b0 : req_write;
				bw_n_next = boot ? 1'b1 : !req_byte;
				opc_n_next = boot ? 1'b0 : !req_fetch;
				seq_next = boot ? 1'b0 : req_seq;
				address_map_enable_n_n_next = !(mode_status == MODE_USER ||
					(!boot && req_translate));
				pend_addr_next = new_addr;
				pend_wd_next = req_wdata;
				taken_next = !boot;
				if (bus.address_latch_enable) begin
					addr_next = new_addr;
				end
				if (boot) begin
					state_next = RBS_RUN;
				end
			end
		end
		if (bus.reset_in) begin
			state_next = RBS_HOLD;
			memory_request_next_n_n_next = 1'b1;
			act_next = 1'b0;
			taken_next = 1'b0;
			it_next = 1'b0;
		end else if (state_reg == RBS_HOLD) begin
			state_next = RBS_BOOT;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_reg <= RBS_HOLD;
			memory_request_next_n_n_reg <= 1'b1;
			rw_reg <= 1'b0;
			bw_n_reg <= 1'b1;
			opc_n_reg <= 1'b1;
			seq_reg <= 1'b0;
			address_map_enable_n_n_reg <= 1'b1;
			mode_n_reg <= 2'h0;
			pend_addr_reg <= '0;
			addr_reg <= '0;
			pend_wd_reg <= '0;
			wd_reg <= '0;
			act_reg <= 1'b0;
			cw_reg <= 1'b0;
			req_taken <= 1'b0;
			cyc_done <= 1'b0;
			cyc_aborted <= 1'b0;
			rd_data <= '0;
			int_take <= 1'b0;
			int_fast <= 1'b0;
			nop_active <= 1'b1;
		end else begin
			state_reg <= state_next;
			memory_request_next_n_n_reg <= memory_request_next_n_n_next;
			rw_reg <= rw_next;
			bw_n_reg <= bw_n_next;
			opc_n_reg <= opc_n_next;
			seq_reg <= seq_next;
			address_map_enable_n_n_reg <= address_map_enable_n_n_next;
			mode_n_reg <= ~mode_status;
			pend_addr_reg <= pend_addr_next;
			addr_reg <= addr_next;
			pend_wd_reg <= pend_wd_next;
			wd_reg <= wd_next;
			act_reg <= act_next;
			cw_reg <= cw_next;
			req_taken <= taken_next;
			cyc_done <= done_next;
			cyc_aborted <= abt_next;
			rd_data <= rd_next;
			int_take <= it_next;
			int_fast <= if_next;
			nop_active <= (state_next == RBS_HOLD);
		end
	end
endmodule : rbs_cpu_end

// ---- hdl/rbs_mem_end.sv ----
// memory system end: phases, control pins, small memory
// assumes the processor end on the same clk_sys
`timescale 1ns/10ps
module rbs_mem_end
	import rbs_pkg::*;
#(
	parameter int DEPTH_W = 8
)
(
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	rbs_bus_if.mem            bus,
	input  wire logic         cpu_reset_req,
	input  wire logic         irq_req,
	input  wire logic         fast_interrupt_n_req,
	input  wire logic         abort_req,
	input  wire logic         rom_mode,
	input  wire logic         bus_enable,
	output logic              seen_valid,
	output logic              seen_write,
	output logic              seen_fetch,
	output logic [ADDR_W-1:0] seen_addr
);
	// ****************************************
	// state
	// ****************************************
	logic [DATA_W-1:0] mem [0:(1<<DEPTH_W)-1];
	logic [1:0]        cnt_reg;
	logic [1:0]        cnt_next;
	logic              ph1_reg;
	logic              ph2_reg;
	logic              abt_reg;
	logic              abt_next;
	logic [DATA_W-1:0] md_reg;
	logic [DATA_W-1:0] md_next;
	logic              moe_reg;
	logic              moe_next;
	logic              cur_act_next;
	logic              cur_act_reg;
	logic              cur_wr_reg;
	logic              cur_byte_reg;
	logic [DEPTH_W-1:0] idx;
	logic [1:0]        lane;
	logic [DATA_W-1:0] word;
	assign bus.phase_1 = ph1_reg;
	assign bus.phase_2 = ph2_reg;
	assign bus.abort_in = abt_reg;
	assign bus.mem_data_out = md_reg;
	assign bus.mem_data_oe = moe_reg;
	assign idx = bus.address_lines[DEPTH_W+1:2];
	assign lane = bus.address_lines[1:0];
	assign word = mem[idx];
	// ****************************************
	// cycle handling
	// ****************************************
	always_comb begin
		cnt_next = cnt_reg + 2'h1;
		abt_next = abt_reg;
		md_next = md_reg;
		moe_next = moe_reg;
		cur_act_next = cur_act_reg;
		if (cnt_reg == SAMPLE_SLOT) begin
			cur_act_next = !bus.memory_request_next_n;
			if (!bus.memory_request_next_n) begin
				abt_next = abort_req &&
					!bus.address_map_enable_n;
				moe_next = !bus.read_write;
				md_next = word;
				if (!bus.byte_word_n) begin
					md_next = {4{word[8*lane+:8]}};
				end
			end
		end
		if (cnt_reg == CLEAR_SLOT) begin
			abt_next = 1'b0;
			moe_next = 1'b0;
			cur_act_next = 1'b0;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_reg <= CLEAR_SLOT;
			ph1_reg <= 1'b0;
			ph2_reg <= 1'b0;
			abt_reg <= 1'b0;
			md_reg <= '0;
			moe_reg <= 1'b0;
			cur_act_reg <= 1'b0;
			cur_wr_reg <= 1'b0;
			cur_byte_reg <= 1'b0;
			seen_valid <= 1'b0;
			seen_write <= 1'b0;
			seen_fetch <= 1'b0;
			seen_addr <= '0;
			bus.reset_in <= 1'b1;
			bus.normal_interrupt_n <= 1'b1;
			bus.fast_interrupt_n <= 1'b1;
			bus.address_drive_enable <= 1'b0;
			bus.data_drive_enable <= 1'b0;
			bus.address_latch_enable <= 1'b1;
		end else begin
			cnt_reg <= cnt_next;
			ph1_reg <= (cnt_next == PH1_SLOT);
			ph2_reg <= (cnt_next == PH2_SLOT);
			abt_reg <= abt_next;
			md_reg <= md_next;
			moe_reg <= moe_next;
			cur_act_reg <= cur_act_next;
			seen_valid <= 1'b0;
			if (cnt_reg == SAMPLE_SLOT) begin
				cur_wr_reg <= bus.read_write;
				cur_byte_reg <= !bus.byte_word_n;
				seen_valid <= !bus.memory_request_next_n;
				seen_write <= bus.read_write;
				seen_fetch <= !bus.instruction_fetch_n;
				seen_addr <= bus.address_lines;
			end
			bus.reset_in <= cpu_reset_req;
			bus.normal_interrupt_n <= !irq_req;
			bus.fast_interrupt_n <= !fast_interrupt_n_req;
			bus.address_drive_enable <= bus_enable;
			bus.data_drive_enable <= bus_enable;
			bus.address_latch_enable <= !rom_mode;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (cnt_reg == PH2_SLOT && cur_act_reg && cur_wr_reg
			&& !abt_reg) begin
			if (cur_byte_reg) begin
				mem[idx][8*lane+:8] <= bus.data_lines[8*lane+:8];
			end else begin
				mem[idx] <= bus.data_lines;
			end
		end
	end
endmodule : rbs_mem_end

// ---- test/rbs_bus_props.sv ----
// assertions on the pins between the two bus ends
// assumes the testbench wires it beside the interface
`timescale 1ns/10ps
module rbs_bus_props
	import rbs_pkg::*;
(
	input wire logic              clk_sys,
	input wire logic              sys_rst,
	input wire logic              phase_1,
	input wire logic              phase_2,
	input wire logic              reset_in,
	input wire logic              abort_in,
	input wire logic              address_drive_enable,
	input wire logic              data_drive_enable,
	input wire logic              address_latch_enable,
	input wire logic [ADDR_W-1:0] address_out,
	input wire logic              cpu_data_oe,
	input wire logic              byte_word_n,
	input wire logic              read_write,
	input wire logic              memory_request_next_n,
	input wire logic              instruction_fetch_n,
	input wire logic              burst_next,
	input wire logic [1:0]        mode_outputs_n,
	input wire logic [ADDR_W-1:0] address_lines
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// ****************************************
	// properties
	// ****************************************
	property p_phase_gap;
		phase_1 |-> !phase_2 ##2 phase_2 ##2 phase_1;
	endproperty
	a_phase_gap: assert property (p_phase_gap)
		else $error("phase order wrong");
	property p_addr_drive;
		address_lines == (address_drive_enable ? address_out : '0);
	endproperty
	a_addr_drive: assert property (p_addr_drive)
		else $error("address drive wrong");
	property p_data_drive;
		cpu_data_oe |-> data_drive_enable && read_write;
	endproperty
	a_data_drive: assert property (p_data_drive)
		else $error("data drive wrong");
	property p_abort_len;
		$rose(abort_in) |=> abort_in ##1 !abort_in;
	endproperty
	a_abort_len: assert property (p_abort_len)
		else $error("abort length wrong");
	property p_early;
		!$past(reset_in) && !$stable({memory_request_next_n, read_write,
			byte_word_n, instruction_fetch_n, burst_next}) |-> $past(phase_2);
	endproperty
	a_early: assert property (p_early)
		else $error("early warning moved late");
	property p_reset_idle;
		reset_in [*6] |-> memory_request_next_n;
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("cycle during reset");
	property p_latch;
		!$stable(address_out) |-> ($past(address_latch_enable) ?
			$past(phase_2) : $past(phase_1));
	endproperty
	a_latch: assert property (p_latch)
		else $error("address changed at wrong time");
	property p_word_mode;
		phase_1 && !memory_request_next_n && byte_word_n &&
			address_drive_enable |=> address_lines[1:0] == ~mode_outputs_n;
	endproperty
	a_word_mode: assert property (p_word_mode)
		else $error("mode missing on low address");
endmodule : rbs_bus_props

// ---- test/rbs_tb.sv ----
// testbench: both bus ends joined by the interface
// assumes the design files and the checker compile first
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	n_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module rbs_tb;
	import rbs_pkg::*;
	typedef struct packed {
		logic              wr, byt, fch, sq, tr;
		logic [1:0]        md;
		logic [ADDR_W-1:0] ad;
		logic [DATA_W-1:0] wd, rd;
	} rbs_row_t;
	logic              clk_sys, sys_rst, req_valid, req_write, req_byte;
	logic              req_fetch, req_seq, req_translate, irq_enable;
	logic              fast_interrupt_n_enable, req_taken, cyc_done, cyc_aborted;
	logic              int_take, int_fast, nop_active, cpu_reset_req;
	logic              irq_req, fast_interrupt_n_req, abort_req, rom_mode, bus_enable;
	logic              seen_valid, seen_write, seen_fetch, ab;
	logic [1:0]        mode_status;
	logic [ADDR_W-1:0] req_addr, seen_addr;
	logic [DATA_W-1:0] req_wdata, rd_data;
	int                n_errors, n_checks, k, cnt;
	rbs_row_t rows [5] = '{
		'{1, 0, 0, 0, 0, 2'h0, 26'h0000010, 32'h11223344, 32'h0},
		'{0, 0, 0, 0, 0, 2'h1, 26'h0000010, 32'h0, 32'h11223344},
		'{1, 1, 0, 1, 0, 2'h2, 26'h0000012, 32'ha5a5a5a5, 32'h0},
		'{0, 1, 1, 0, 1, 2'h3, 26'h0000012, 32'h0, 32'ha5a5a5a5},
		'{0, 0, 1, 1, 0, 2'h0, 26'h0000010, 32'h0, 32'h11a53344}};
	rbs_bus_if bus ();
	rbs_cpu_end u_rbs_cpu_end (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.bus(bus), .req_valid(req_valid), .req_write(req_write),
		.req_byte(req_byte), .req_fetch(req_fetch), .req_seq(req_seq),
		.req_translate(req_translate), .req_addr(req_addr),
		.req_wdata(req_wdata), .mode_status(mode_status),
		.irq_enable(irq_enable), .fast_interrupt_n_enable(fast_interrupt_n_enable),
		.req_taken(req_taken), .cyc_done(cyc_done),
		.cyc_aborted(cyc_aborted), .rd_data(rd_data), .int_take(int_take),
		.int_fast(int_fast), .nop_active(nop_active));
	rbs_mem_end #(.DEPTH_W(8)) u_rbs_mem_end (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .bus(bus), .cpu_reset_req(cpu_reset_req),
		.irq_req(irq_req), .fast_interrupt_n_req(fast_interrupt_n_req), .abort_req(abort_req),
		.rom_mode(rom_mode), .bus_enable(bus_enable),
		.seen_valid(seen_valid), .seen_write(seen_write),
		.seen_fetch(seen_fetch), .seen_addr(seen_addr));
	rbs_bus_props u_rbs_bus_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.phase_1(bus.phase_1), .phase_2(bus.phase_2),
		.reset_in(bus.reset_in), .abort_in(bus.abort_in),
		.address_drive_enable(bus.address_drive_enable),
		.data_drive_enable(bus.data_drive_enable),
		.address_latch_enable(bus.address_latch_enable),
		.address_out(bus.address_out), .cpu_data_oe(bus.cpu_data_oe),
		.byte_word_n(bus.byte_word_n), .read_write(bus.read_write),
		.memory_request_next_n(bus.memory_request_next_n),
		.instruction_fetch_n(bus.instruction_fetch_n),
		.burst_next(bus.burst_next), .mode_outputs_n(bus.mode_outputs_n),
		.address_lines(bus.address_lines));
	// ****************************************
	// tasks
	// ****************************************
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	task automatic run_cyc(input rbs_row_t r, output logic abt);
		mode_status = r.md;
		@(negedge clk_sys);
		{req_write, req_byte, req_fetch, req_seq} = {r.wr, r.byt, r.fch, r.sq};
		req_translate = r.tr;
		req_addr = r.ad;
		req_wdata = r.wd;
		req_valid = 1'b1;
		for (k = 0; k < 12 && req_taken !== 1'b1; k++) @(negedge clk_sys);
		req_valid = 1'b0;
		`CHK("memory_request_next_n", 1'b0, bus.memory_request_next_n)
		`CHK("rw", r.wr, bus.read_write)
		`CHK("bw", ~r.byt, bus.byte_word_n)
		`CHK("opc", ~r.fch, bus.instruction_fetch_n)
		`CHK("seq", r.sq, bus.burst_next)
		`CHK("tr", ~(r.tr | (r.md == MODE_USER)), bus.address_map_enable_n)
		`CHK("mode", ~r.md, bus.mode_outputs_n)
		for (k = 0; k < 12 && cyc_done !== 1'b1 && cyc_aborted !== 1'b1; k++)
			@(negedge clk_sys);
		abt = cyc_aborted;
		if (abt !== 1'b1) begin
			if (!r.wr) `CHK("rdata", r.rd, rd_data)
			`CHK("kind", {r.wr, r.fch}, {seen_write, seen_fetch})
			`CHK("addr", r.byt ? r.ad : {r.ad[25:2], r.md}, seen_addr)
		end
	endtask : run_cyc
	// ****************************************
	// clock, watchdog, tests
	// ****************************************
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		#100000;
		n_errors++;
		$display("watchdog expired");
		stop_test();
	end
	initial begin
		{sys_rst, bus_enable} = 2'b11;
		{req_valid, req_write, req_byte, req_fetch, req_seq} = 5'h00;
		{req_translate, irq_enable, fast_interrupt_n_enable, cpu_reset_req} = 4'h0;
		{irq_req, fast_interrupt_n_req, abort_req, rom_mode} = 4'h0;
		{req_addr, req_wdata, mode_status} = '0;
		repeat (7) @(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (30) @(negedge clk_sys);
		foreach (rows[i]) begin
			run_cyc(rows[i], ab);
			`CHK("done", 1'b0, ab)
		end
		$display("test table done");
		abort_req = 1'b1;
		run_cyc(rbs_row_t'{1, 0, 0, 0, 1, 2'h0, 26'h10, 32'hdeadbeef, 0}, ab);
		abort_req = 1'b0;
		`CHK("aborted", 1'b1, ab)
		run_cyc(rows[4], ab);
		$display("test abort done");
		{irq_enable, fast_interrupt_n_enable, irq_req} = 3'h7;
		for (k = 0; k < 20 && int_take !== 1'b1; k++) @(negedge clk_sys);
		`CHK("irq", 2'b10, {int_take, int_fast})
		fast_interrupt_n_req = 1'b1;
		for (k = 0; k < 20 && {int_take, int_fast} !== 2'b11; k++)
			@(negedge clk_sys);
		`CHK("fast_interrupt_n", 2'b11, {int_take, int_fast})
		{irq_enable, fast_interrupt_n_enable} = 2'b00;
		repeat (12) @(negedge clk_sys);
		cnt = 0;
		repeat (16) begin
			@(negedge clk_sys);
			if (int_take !== 1'b0) cnt++;
		end
		`CHK("masked", 0, cnt)
		{irq_req, fast_interrupt_n_req} = 2'b00;
		$display("test interrupts done");
		bus_enable = 1'b0;
		repeat (3) @(negedge clk_sys);
		`CHK("abe", {ADDR_W{1'b0}}, bus.address_lines)
		`CHK("dbe", 1'b0, bus.cpu_data_oe)
		bus_enable = 1'b1;
		rom_mode = 1'b1;
		repeat (4) @(negedge clk_sys);
		run_cyc(rows[4], ab);
		rom_mode = 1'b0;
		$display("test enables done");
		cpu_reset_req = 1'b1;
		repeat (8) @(negedge clk_sys);
		`CHK("nop", 2'b11, {nop_active, bus.memory_request_next_n})
		cpu_reset_req = 1'b0;
		for (k = 0; k < 30 && seen_valid !== 1'b1; k++) @(negedge clk_sys);
		`CHK("boot", {1'b1, RESET_VECTOR[25:2], mode_status}, {seen_fetch, seen_addr})
		$display("test reset done");
		stop_test();
	end
endmodule : rbs_tb
